// *** micgr_params.svh ***
// Offsets, field positions, reset values and timing counts of the mic gain and route bank.
`ifndef MICGR_PARAMS_SVH
`define MICGR_PARAMS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define MICGR_PAGE_CTRL_ADDR 7'h00
`define MICGR_BANK_PAGE 8'h01
`define MICGR_GAIN_ADDR 7'h2f
`define MICGR_POS_SEL_ADDR 7'h30
`define MICGR_NEG_SEL_ADDR 7'h31
`define MICGR_CM_ADDR 7'h32
`define MICGR_RSVD_FIRST_ADDR 7'h33
`define MICGR_RSVD_LAST_ADDR 7'h7f

// ****************************************************************
// Reset values
// ****************************************************************
`define MICGR_PAGE_RESET 8'h00
`define MICGR_GAIN_RESET 8'h80
`define MICGR_POS_SEL_RESET 8'h00
`define MICGR_NEG_SEL_RESET 8'h00
`define MICGR_CM_RESET 8'h00
`define MICGR_READ_ZERO 8'h00

// ****************************************************************
// Field positions
// ****************************************************************
`define MICGR_GAIN_OVR_BIT 7
`define MICGR_GAIN_CODE_MSB 6
`define MICGR_GAIN_CODE_MAX 7'h77
`define MICGR_GAIN_ZERO_DB 7'h00
`define MICGR_POS_LP_MSB 7
`define MICGR_POS_LP_LSB 6
`define MICGR_POS_RP_MSB 5
`define MICGR_POS_RP_LSB 4
`define MICGR_POS_LM_MSB 3
`define MICGR_POS_LM_LSB 2
`define MICGR_NEG_CM_MSB 7
`define MICGR_NEG_CM_LSB 6
`define MICGR_NEG_LM_MSB 5
`define MICGR_NEG_LM_LSB 4
`define MICGR_CM_LP_BIT 7
`define MICGR_CM_RP_BIT 6
`define MICGR_CM_LM_BIT 5
`define MICGR_CM_RW_MSB 7
`define MICGR_CM_RW_LSB 1
`define MICGR_ROUTE_OFF 2'h0

// ****************************************************************
// Timing
// ****************************************************************
`define MICGR_CLK_MHZ 125
`define MICGR_STEP_TIME_NS 1000
`define MICGR_STEP_CYCLES ((`MICGR_STEP_TIME_NS * `MICGR_CLK_MHZ) / 1000)
`define MICGR_TICK_ZERO 8'h00

`endif

// *** micgr_pkg.sv ***
// Types shared by the mic gain and route bank modules.
package micgr_pkg;

    // Settling sequencer states.
    typedef enum logic [0:0] {MICGR_IDLE, MICGR_STEP} micgr_step_state_type;

    // One routing field: 00 off, 01 10k, 10 20k, 11 40k.
    typedef logic [1:0] micgr_route_type;

endpackage

// *** micgr_stepper.sv ***
// Gain settling sequencer that walks the applied gain to its target and reports completion.
`timescale 1ns/100ps
`default_nettype none
`include "micgr_params.svh"

module micgr_stepper
    import micgr_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // New setting written.
    input wire logic restart,
    // Requested gain code and routing fields.
    input wire logic [6:0] target_gain,
    input wire logic [9:0] target_route,
    // Settings actually in force.
    output logic [6:0] applied_gain,
    output logic [9:0] applied_route,
    output logic applied_done
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        micgr_step_state_type state;
        logic [7:0] tick_cnt;
        logic [6:0] gain;
        logic [9:0] route;
        logic done;
    } micgr_stepper_state_type;

    micgr_stepper_state_type st_reg; // Registered state.
    micgr_stepper_state_type st_next; // Next state.

    // Gain moves one 0.5 dB code per tick, so large changes ramp instead of clicking.
    always_comb
    begin
        st_next = st_reg;
        if (st_reg.tick_cnt == 8'(`MICGR_STEP_CYCLES - 1))
        begin
            st_next.tick_cnt = `MICGR_TICK_ZERO;
        end
        else
        begin
            st_next.tick_cnt = st_reg.tick_cnt + 8'h01;
        end
        unique case (st_reg.state)
            MICGR_IDLE:
            begin
                // A write drops the flag at once.
                if (restart)
                begin
                    st_next.state = MICGR_STEP;
                    st_next.done = 1'b0;
                end
            end
            MICGR_STEP:
            begin
                st_next.done = 1'b0;
                if (st_reg.tick_cnt == `MICGR_TICK_ZERO && !restart)
                begin
                    if (st_reg.gain < target_gain)
                    begin
                        st_next.gain = st_reg.gain + 7'h01;
                    end
                    else if (st_reg.gain > target_gain)
                    begin
                        st_next.gain = st_reg.gain - 7'h01;
                    end
                    else
                    begin
                        // Routing switches only once the gain has landed.
                        st_next.route = target_route;
                        st_next.done = 1'b1;
                        st_next.state = MICGR_IDLE;
                    end
                end
            end
        endcase
    end

    // Start settling after reset so the flag rises once the reset setting holds.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_reg <= '{state: MICGR_STEP, tick_cnt: `MICGR_TICK_ZERO,
                        gain: `MICGR_GAIN_ZERO_DB, route: 10'h000, done: 1'b0};
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign applied_gain = st_reg.gain;
    assign applied_route = st_reg.route;
    assign applied_done = st_reg.done;

endmodule
`default_nettype wire

// *** micgr_regs.sv ***
// Mic gain and ADC input routing register bank on the paged control port.
// Operation
// - Override bit forces gain stage to 0 dB.
// - Gain code is 0.5 dB per step.
// - Bits 7:6 route left plus input.
// - Bits 5:4 route right plus input.
// - Bits 3:2 route left minus positively.
// - Negative field routes common mode, left minus.
// - CM bit 7 ties unused left plus.
// - CM bit 6 ties unused right plus.
// - CM bit 5 ties unused left minus.
// - CM bit 0 reads gains applied flag.
`timescale 1ns/100ps
`default_nettype none
`include "micgr_params.svh"

module micgr_regs
    import micgr_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Register access from the serial control port decoder.
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic [7:0] page_sel,
    // Analog bypass usage from the output mixer settings.
    input wire logic bypass_uses_left_plus,
    input wire logic bypass_uses_right_plus,
    // Gain stage controls.
    output logic [6:0] gain_stage_code,
    // Feed-forward resistance selects, 00 means unconnected.
    output logic [1:0] pos_left_plus_sel,
    output logic [1:0] pos_right_plus_sel,
    output logic [1:0] pos_left_minus_sel,
    output logic [1:0] neg_common_mode_sel,
    output logic [1:0] neg_left_minus_sel,
    // Common-mode tie-offs for unused inputs.
    output logic left_plus_tie_cm,
    output logic right_plus_tie_cm,
    output logic left_minus_tie_cm
);

    // ****************************************************************
    // Helpers
    // ****************************************************************

    // Effective gain code; reserved codes clamp to the top step as a safety net.
    function automatic logic [6:0] gain_code_of(input logic [7:0] ctrl);
        logic [6:0] code;
        code = ctrl[`MICGR_GAIN_CODE_MSB:0];
        if (ctrl[`MICGR_GAIN_OVR_BIT])
        begin
            code = `MICGR_GAIN_ZERO_DB;
        end
        else if (code > `MICGR_GAIN_CODE_MAX)
        begin
            code = `MICGR_GAIN_CODE_MAX;
        end
        return code;
    endfunction

    // A routing field is in use whenever it is not 00.
    function automatic logic route_used(input micgr_route_type sel);
        return sel != `MICGR_ROUTE_OFF;
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [7:0] page;
        logic [7:0] gain_ctrl;
        logic [7:0] pos_sel;
        logic [7:0] neg_sel;
        logic [6:0] cm_ctrl;
        logic [7:0] rdata;
        logic restart;
        logic lp_tie;
        logic rp_tie;
        logic lm_tie;
    } micgr_regs_state_type;

    micgr_regs_state_type st_reg; // Registered state.
    micgr_regs_state_type st_next; // Next state.

    logic in_bank; // Access targets page 1.
    logic [6:0] applied_gain; // Gain in force.
    logic [9:0] applied_route; // Routing in force.
    logic applied_done; // All gains applied.

    // Settling sequencer; the analog controls follow its applied values.
    micgr_stepper u_stepper (
        .clk(clk),
        .rst(rst),
        .restart(st_reg.restart),
        .target_gain(gain_code_of(st_reg.gain_ctrl)),
        .target_route({st_reg.pos_sel[`MICGR_POS_LP_MSB:`MICGR_POS_LM_LSB],
                       st_reg.neg_sel[`MICGR_NEG_CM_MSB:`MICGR_NEG_LM_LSB]}),
        .applied_gain(applied_gain),
        .applied_route(applied_route),
        .applied_done(applied_done)
    );

    assign in_bank = (st_reg.page == `MICGR_BANK_PAGE);

    // ****************************************************************
    // Register access and tie-off decode
    // ****************************************************************

    // Writes store whole bytes, reserved bits included, so they read back as written, except CM bit 0, which is never stored.
    always_comb
    begin
        st_next = st_reg;
        st_next.restart = 1'b0;
        if (reg_wr_en)
        begin
            if (reg_addr == `MICGR_PAGE_CTRL_ADDR)
            begin
                st_next.page = reg_wdata;
            end
            else if (in_bank)
            begin
                unique case (reg_addr)
                    `MICGR_GAIN_ADDR:
                    begin
                        st_next.gain_ctrl = reg_wdata;
                        st_next.restart = 1'b1;
                    end
                    `MICGR_POS_SEL_ADDR:
                    begin
                        st_next.pos_sel = reg_wdata;
                        st_next.restart = 1'b1;
                    end
                    `MICGR_NEG_SEL_ADDR:
                    begin
                        st_next.neg_sel = reg_wdata;
                        st_next.restart = 1'b1;
                    end
                    `MICGR_CM_ADDR:
                    begin
                        // Bit 0 is the status flag and is not writable.
                        st_next.cm_ctrl = reg_wdata[`MICGR_CM_RW_MSB:`MICGR_CM_RW_LSB];
                    end
                    default:
                    begin
                        // Reserved space keeps nothing, so a write there has no effect.
                        st_next.cm_ctrl = st_reg.cm_ctrl;
                    end
                endcase
            end
        end
        // Read data is captured on the clock edge that samples the strobe.
        if (reg_rd_en)
        begin
            st_next.rdata = `MICGR_READ_ZERO;
            if (reg_addr == `MICGR_PAGE_CTRL_ADDR)
            begin
                st_next.rdata = st_reg.page;
            end
            else if (in_bank)
            begin
                unique case (reg_addr)
                    `MICGR_GAIN_ADDR: st_next.rdata = st_reg.gain_ctrl;
                    `MICGR_POS_SEL_ADDR: st_next.rdata = st_reg.pos_sel;
                    `MICGR_NEG_SEL_ADDR: st_next.rdata = st_reg.neg_sel;
                    `MICGR_CM_ADDR: st_next.rdata = {st_reg.cm_ctrl, applied_done};
                    default: st_next.rdata = `MICGR_READ_ZERO;
                endcase
            end
        end
        // Tie an input to common mode only while nothing else uses it.
        st_next.lp_tie = st_reg.cm_ctrl[`MICGR_CM_LP_BIT - 1] && !bypass_uses_left_plus
            && !route_used(applied_route[9:8]);
        st_next.rp_tie = st_reg.cm_ctrl[`MICGR_CM_RP_BIT - 1] && !bypass_uses_right_plus
            && !route_used(applied_route[7:6]);
        st_next.lm_tie = st_reg.cm_ctrl[`MICGR_CM_LM_BIT - 1]
            && !route_used(applied_route[5:4])
            && !route_used(applied_route[1:0]);
    end

    // All bank state in one register.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_reg <= '{page: `MICGR_PAGE_RESET, gain_ctrl: `MICGR_GAIN_RESET,
                        pos_sel: `MICGR_POS_SEL_RESET, neg_sel: `MICGR_NEG_SEL_RESET,
                        cm_ctrl: 7'h00, rdata: `MICGR_READ_ZERO, restart: 1'b0,
                        lp_tie: 1'b0, rp_tie: 1'b0, lm_tie: 1'b0};
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign reg_rdata = st_reg.rdata;
    assign page_sel = st_reg.page;
    assign gain_stage_code = applied_gain;
    assign pos_left_plus_sel = applied_route[9:8];
    assign pos_right_plus_sel = applied_route[7:6];
    assign pos_left_minus_sel = applied_route[5:4];
    assign neg_common_mode_sel = applied_route[3:2];
    assign neg_left_minus_sel = applied_route[1:0];
    assign left_plus_tie_cm = st_reg.lp_tie;
    assign right_plus_tie_cm = st_reg.rp_tie;
    assign left_minus_tie_cm = st_reg.lm_tie;

endmodule
`default_nettype wire

// *** micgr_regs_sva.sv ***
// Assertion checker for the mic gain and input route register bank.
`timescale 1ns/100ps
`default_nettype none

// ********************************
// Checker
// ********************************
module micgr_regs_sva
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Read side of the register port.
    input wire logic reg_rd_en,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_rdata,
    // Analog controls.
    input wire logic bypass_uses_left_plus,
    input wire logic bypass_uses_right_plus,
    input wire logic [6:0] gain_stage_code,
    input wire logic [1:0] pos_left_plus_sel,
    input wire logic [1:0] pos_right_plus_sel,
    input wire logic [1:0] pos_left_minus_sel,
    input wire logic [1:0] neg_common_mode_sel,
    input wire logic [1:0] neg_left_minus_sel,
    input wire logic left_plus_tie_cm,
    input wire logic right_plus_tie_cm,
    input wire logic left_minus_tie_cm
);
    // Cycles since the gain last moved; starts saturated so reset never fires a check.
    logic [7:0] gap_reg;
    logic [7:0] gap_next;
    // Gain seen at the last edge, kept in clocked code so the move test needs no sampled value.
    logic [6:0] prev_gain_reg;

    // Clear on a gain move, otherwise count up and stick at the top.
    always_comb
    begin
        gap_next = (gap_reg == 8'hff) ? gap_reg : gap_reg + 8'h01;
        if (gain_stage_code != prev_gain_reg)
        begin
            gap_next = 8'h00;
        end
    end

    // Register the gap counter and the previous gain; the gain resets to 0 dB.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            gap_reg <= 8'hff;
            prev_gain_reg <= 7'h00;
        end
        else
        begin
            gap_reg <= gap_next;
            prev_gain_reg <= gain_stage_code;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_gain_ceiling: assert property (gain_stage_code <= 7'h77)
        else $error("gain code above the top step");
    a_gain_one_step: assert property ($changed(gain_stage_code) |->
        (gain_stage_code - $past(gain_stage_code)) inside {7'h01, 7'h7f})
        else $error("gain moved by more than one step");
    a_step_spacing: assert property ($changed(gain_stage_code) |-> gap_reg >= 8'h7c)
        else $error("gain stepped too soon");
    a_route_after_ramp: assert property ($changed({pos_left_plus_sel, pos_right_plus_sel,
        pos_left_minus_sel, neg_common_mode_sel, neg_left_minus_sel})
        |-> $stable(gain_stage_code))
        else $error("routing moved while gain was ramping");
    a_tie_left_plus: assert property (left_plus_tie_cm |->
        $past(pos_left_plus_sel) == 2'h0 && !$past(bypass_uses_left_plus))
        else $error("left plus tied while in use");
    a_tie_right_plus: assert property (right_plus_tie_cm |->
        $past(pos_right_plus_sel) == 2'h0 && !$past(bypass_uses_right_plus))
        else $error("right plus tied while in use");
    a_tie_left_minus: assert property (left_minus_tie_cm |->
        $past(pos_left_minus_sel) == 2'h0 && $past(neg_left_minus_sel) == 2'h0)
        else $error("left minus tied while in use");
    a_reserved_reads: assert property (reg_rd_en && reg_addr >= 7'h33
        |=> reg_rdata == 8'h00)
        else $error("reserved address read nonzero");
endmodule

bind micgr_regs micgr_regs_sva u_sva (.clk(clk), .rst(rst), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_rdata(reg_rdata), .bypass_uses_left_plus(bypass_uses_left_plus),
    .bypass_uses_right_plus(bypass_uses_right_plus), .gain_stage_code(gain_stage_code),
    .pos_left_plus_sel(pos_left_plus_sel), .pos_right_plus_sel(pos_right_plus_sel),
    .pos_left_minus_sel(pos_left_minus_sel), .neg_common_mode_sel(neg_common_mode_sel),
    .neg_left_minus_sel(neg_left_minus_sel), .left_plus_tie_cm(left_plus_tie_cm),
    .right_plus_tie_cm(right_plus_tie_cm), .left_minus_tie_cm(left_minus_tie_cm));

`default_nettype wire

// *** micgr_host.sv ***
// Host model that issues byte writes and reads on the control port.
`timescale 1ns/100ps
`default_nettype none

// ********************************
// Host
// ********************************
module micgr_host
(
    // Clock.
    input wire logic clk,
    // Register port.
    output logic reg_wr_en,
    output logic reg_rd_en,
    output logic [6:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    // Idle bus at time zero.
    initial
    begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = 7'h55;
        reg_wdata = 8'haa;
    end

    // One-cycle write; address and data are inverted once released so stale values never match.
    // Callers pass only legal gain codes, zero reserved bits and reset values.
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr_en = 1'b1;
        @(negedge clk);
        reg_wr_en = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask

    // One-cycle read; the byte is taken on the falling edge, half a cycle after the clock edge that samples the strobe.
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_rd_en = 1'b1;
        @(negedge clk);
        reg_rd_en = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
    endtask
endmodule

`default_nettype wire

// *** mic_gain_input_route_regs_tb_top.sv ***
// Self-checking testbench for the mic gain and input route register bank.
`timescale 1ns/100ps
`default_nettype none

// ********************************
// Testbench
// ********************************
module mic_gain_input_route_regs_tb_top;
    // Stimulus and observed signals.
    logic clk = 1'b0;
    logic rst;
    logic byp_lp;
    logic byp_rp;
    wire logic wr_en, rd_en, lp_tie, rp_tie, lm_tie;
    wire logic [6:0] addr, gain;
    wire logic [7:0] wdata, rdata, page;
    wire logic [1:0] p_lp, p_rp, p_lm, n_cm, n_lm;
    int miscompares = 0;
    int cmp_count = 0;
    logic [7:0] v;

    // 125 MHz clock.
    always #4 clk = ~clk;

    micgr_host host (.clk(clk), .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr),
        .reg_wdata(wdata), .reg_rdata(rdata));

    micgr_regs DUT (.clk(clk), .rst(rst), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
        .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .page_sel(page),
        .bypass_uses_left_plus(byp_lp), .bypass_uses_right_plus(byp_rp),
        .gain_stage_code(gain), .pos_left_plus_sel(p_lp), .pos_right_plus_sel(p_rp),
        .pos_left_minus_sel(p_lm), .neg_common_mode_sel(n_cm), .neg_left_minus_sel(n_lm),
        .left_plus_tie_cm(lp_tie), .right_plus_tie_cm(rp_tie), .left_minus_tie_cm(lm_tie));

    // Print counts and the verdict, then stop.
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Compare one byte, four-state exact.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Poll the applied flag with a bound; a full gain ramp fits inside it.
    task automatic wait_flag();
        int i;
        for (i = 0; i < 9000; i++)
        begin
            host.rd(7'h32, v);
            if (v[0] === 1'b1)
                return;
        end
        miscompares++;
        $display("Error at %0t: settle timeout", $time);
        give_verdict();
    endtask

    // Reset values; the reset gain and routes are in force at once, so the flag is already up.
    task automatic t_reset();
        host.wr(7'h00, 8'h01);
        host.rd(7'h32, v); chk(v, 8'h01);
        host.rd(7'h2f, v); chk(v, 8'h80);
        host.rd(7'h30, v); chk(v, 8'h00);
        host.rd(7'h31, v); chk(v, 8'h00);
        wait_flag();
        chk({1'b0, gain}, 8'h00);
        $display("reset test done");
    endtask

    // Full-scale ramp up, then the override pulls it back to 0 dB.
    task automatic t_gain();
        host.wr(7'h2f, 8'h77);
        host.rd(7'h32, v); chk(v, 8'h00);
        wait_flag();
        chk({1'b0, gain}, 8'h77);
        host.rd(7'h2f, v); chk(v, 8'h77);
        host.wr(7'h2f, 8'hf7);
        wait_flag();
        chk({1'b0, gain}, 8'h00);
        $display("gain test done");
    endtask

    // Every route code on every field, ending with all routes off.
    task automatic t_routes();
        int j;
        logic [1:0] k;
        for (j = 3; j >= 0; j--)
        begin
            k = j[1:0];
            host.wr(7'h30, {k, k, k, 2'h0});
            host.wr(7'h31, {k, k, 4'h0});
            wait_flag();
            chk({p_lp, p_rp, p_lm, n_cm}, {4{k}});
            chk({6'h00, n_lm}, {6'h00, k});
            host.rd(7'h30, v); chk(v, {k, k, k, 2'h0});
        end
        $display("route test done");
    endtask

    // Tie-offs follow the enable bits and yield to bypass or gain stage use.
    task automatic t_ties();
        @(negedge clk) byp_lp = 1'b1;
        host.wr(7'h32, 8'he0);
        repeat (3) @(negedge clk);
        chk({5'h00, lp_tie, rp_tie, lm_tie}, 8'h03);
        host.rd(7'h32, v); chk(v, 8'he1);
        byp_lp = 1'b0;
        byp_rp = 1'b1;
        repeat (3) @(negedge clk);
        chk({5'h00, lp_tie, rp_tie, lm_tie}, 8'h05);
        byp_rp = 1'b0;
        host.wr(7'h30, 8'h44);
        wait_flag();
        repeat (2) @(negedge clk);
        chk({5'h00, lp_tie, rp_tie, lm_tie}, 8'h02);
        $display("tie test done");
    endtask

    // Reserved range and foreign pages read zero and ignore writes.
    task automatic t_reserved();
        host.rd(7'h33, v); chk(v, 8'h00);
        host.wr(7'h7f, 8'h00);
        host.rd(7'h7f, v); chk(v, 8'h00);
        host.wr(7'h00, 8'h00);
        host.rd(7'h2f, v); chk(v, 8'h00);
        host.wr(7'h2f, 8'h10);
        host.wr(7'h00, 8'h01);
        host.rd(7'h2f, v); chk(v, 8'hf7);
        chk(page, 8'h01);
        $display("reserved test done");
    endtask

    // Main sequence.
    initial
    begin
        rst = 1'b1;
        byp_lp = 1'b0;
        byp_rp = 1'b0;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        t_reset();
        t_gain();
        t_routes();
        t_ties();
        t_reserved();
        give_verdict();
    end
endmodule

`default_nettype wire
